// [dv/icu_pin_src.sv]
// Pin source model: outside drivers and the port loopback on the pins.
`timescale 1ns/1ps
`default_nettype none

module icu_pin_src (
    input wire logic [3:0] ext_i,
    input wire logic [3:0] port_i,
    input wire logic [3:0] oe_i,
    output logic [3:0] lvl_o
);
    // driven pin follows port latch
    // A driven pin shows the port latch, so port writes reach the capture
    // path; an input pin shows the outside source.
    assign lvl_o = (oe_i & port_i) | (~oe_i & ext_i);
endmodule : icu_pin_src

`default_nettype wire

// [dv/icu_top_test.sv]
// Self-checking bench for the input capture unit.
`timescale 1ns/1ps
`default_nettype none

module icu_top_test
    import icu_pkg::*;
;
    logic sys_clk = 0;
    logic rst = 1;
    logic [7:0] awaddr = 0;
    logic [7:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] ext = 0;
    logic [3:0] pin, pin_out, pin_oe;
    logic [15:0] tmr = 0;
    logic [1:0] tdiv = 0;
    int error_cnt = 0;
    int checks = 0;

    // Free-running 50 ns clock
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // timer synchronous to the system clock
    // timer ticks once per four clocks
    // Odd step changes both bytes on each tick, exposing latch slips
    always @(posedge sys_clk) begin
        tdiv <= tdiv + 2'h1;
        if (tdiv == 2'h3) begin
            tmr <= tmr + 16'h0111;
        end
    end

    icu_pin_src src (.ext_i(ext), .port_i(pin_out), .oe_i(pin_oe),
        .lvl_o(pin));

    icu_top dut (
        .sys_clk_i(sys_clk), .reset_i(rst),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .capture_input_pin_i(pin),
        .capture_input_pin_o(pin_out), .capture_input_pin_oe_o(pin_oe),
        .timer_one_count_high_i(tmr[15:8]),
        .timer_one_count_low_i(tmr[7:0]), .irq_o(irq)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // Bus write; each channel released as soon as it is taken
    // Handshakes are judged at the falling edge, where the design's
    // outputs have settled, and acted on just after the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            output logic [1:0] r);
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        aw_hit = 1'b0;
        w_hit = 1'b0;
        b_hit = 1'b0;
        r = 2'h3;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // No cycle limit here; only the watchdog ends a wait
        while (!b_hit) begin
            @(negedge sys_clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            r = bresp;
            @(posedge sys_clk);
            if (aw_hit) begin
                awvalid <= 1'b0;
            end
            if (w_hit) begin
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
    endtask : wr

    // Bus read; rready held until the data beat is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        logic ar_hit;
        logic r_hit;
        ar_hit = 1'b0;
        r_hit = 1'b0;
        r = 2'h3;
        d = 32'hdead_beef;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // Data stands until the edge that takes it, so the falling-edge
        // sample is the value handed over at that edge
        while (!r_hit) begin
            @(negedge sys_clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
            if (ar_hit) begin
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
    endtask : rd

    task automatic wrk(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask : wrk

    task automatic rchk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, want);
    endtask : rchk

    function automatic logic [7:0] ctl(input int c);
        return ICU_CTRL_BASE + 8'(4 * c);
    endfunction : ctl

    function automatic logic [7:0] val(input int c);
        return ICU_VALUE_BASE + 8'(4 * c);
    endfunction : val

    // Pin change; e is the timer seen at the third edge after it
    task automatic pin_edge(input int c, input logic lvl,
            output logic [15:0] e);
        @(posedge sys_clk);
        ext[c] <= lvl;
        repeat (3) @(posedge sys_clk);
        e = tmr;
        repeat (2) @(posedge sys_clk);
    endtask : pin_edge

    task automatic pulses(input int c, input int k);
        logic [15:0] e;
        for (int i = 0; i < k; i++) begin
            pin_edge(c, 1'b1, e);
            pin_edge(c, 1'b0, e);
        end
    endtask : pulses

    task automatic do_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        for (int c = 0; c < 4; c++) rchk(ctl(c), 0);
        rchk(ICU_FLAG_OFS, 0);
        rchk(ICU_MASK_OFS, 0);
        rchk(ICU_PORT_OFS, 32'hf0);
        chk(pin_oe, 0);
        chk(irq, 0);
        rd(8'h40, d, r);
        chk(r, ICU_RESP_SLVERR);
        wr(8'h40, 32'h5, r);
        chk(r, ICU_RESP_SLVERR);
        wr(val(0), 32'hffff, r);
        chk(r, ICU_RESP_OKAY);
        rchk(val(0), 0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_edges;
        logic [15:0] e, x;
        for (int c = 0; c < 4; c++) begin
            wrk(ctl(c), ICU_MODE_RISE);
            wrk(ICU_FLAG_OFS, 32'hf);
            pin_edge(c, 1'b1, e);
            rchk(val(c), e);
            rchk(ICU_FLAG_OFS, 32'(1 << c));
            wrk(ctl(c), ICU_MODE_FALL);
            wrk(ICU_FLAG_OFS, 32'hf);
            pin_edge(c, 1'b0, e);
            rchk(val(c), e);
            rchk(ICU_FLAG_OFS, 32'(1 << c));
            wrk(ICU_FLAG_OFS, 32'hf);
            pin_edge(c, 1'b1, x);
            rchk(ICU_FLAG_OFS, 0);
            rchk(val(c), e);
            wrk(ctl(c), ICU_MODE_OFF);
            // Leave the pin low so later pulse counts start from idle
            pin_edge(c, 1'b0, x);
        end
        $display("t_edges done");
    endtask : t_edges

    task automatic t_prescale;
        wrk(ctl(1), ICU_MODE_RISE4);
        wrk(ICU_FLAG_OFS, 32'hf);
        pulses(1, 3);
        rchk(ICU_FLAG_OFS, 0);
        pulses(1, 1);
        rchk(ICU_FLAG_OFS, 32'h2);
        pulses(1, 2);
        wrk(ctl(1), ICU_MODE_OFF);
        wrk(ctl(1), ICU_MODE_RISE4);
        wrk(ICU_FLAG_OFS, 32'hf);
        pulses(1, 3);
        rchk(ICU_FLAG_OFS, 0);
        pulses(1, 1);
        rchk(ICU_FLAG_OFS, 32'h2);
        wrk(ICU_FLAG_OFS, 32'hf);
        pulses(1, 2);
        wrk(ctl(1), ICU_MODE_RISE16);
        wrk(ICU_FLAG_OFS, 32'hf);
        pulses(1, 13);
        rchk(ICU_FLAG_OFS, 0);
        pulses(1, 1);
        rchk(ICU_FLAG_OFS, 32'h2);
        pulses(1, 2);
        do_reset();
        wrk(ctl(1), ICU_MODE_RISE4);
        wrk(ICU_FLAG_OFS, 32'hf);
        pulses(1, 3);
        rchk(ICU_FLAG_OFS, 0);
        pulses(1, 1);
        rchk(ICU_FLAG_OFS, 32'h2);
        wrk(ctl(1), ICU_MODE_OFF);
        $display("t_prescale done");
    endtask : t_prescale

    task automatic t_irq;
        logic [15:0] e;
        wrk(ctl(2), ICU_MODE_RISE);
        wrk(ICU_FLAG_OFS, 32'hf);
        pin_edge(2, 1'b1, e);
        pin_edge(2, 1'b0, e);
        pin_edge(2, 1'b1, e);
        rchk(val(2), e);
        chk(irq, 0);
        wrk(ICU_MASK_OFS, 32'h4);
        rchk(ICU_MASK_OFS, 32'h4);
        chk(irq, 1);
        repeat (40) @(posedge sys_clk);
        wrk(ICU_FLAG_OFS, 32'hb);
        rchk(ICU_FLAG_OFS, 32'h4);
        wrk(ICU_FLAG_OFS, 32'h4);
        rchk(ICU_FLAG_OFS, 0);
        chk(irq, 0);
        wrk(ICU_MASK_OFS, 0);
        wrk(ctl(2), ICU_MODE_OFF);
        $display("t_irq done");
    endtask : t_irq

    task automatic t_port;
        wrk(ctl(3), ICU_MODE_RISE);
        wrk(ICU_PORT_OFS, 32'h70);
        rchk(ICU_PORT_OFS, 32'h70);
        chk(pin_oe, 4'h8);
        wrk(ICU_FLAG_OFS, 32'hf);
        wrk(ICU_PORT_OFS, 32'h78);
        repeat (4) @(posedge sys_clk);
        chk(pin_out, 4'h8);
        rchk(ICU_FLAG_OFS, 32'h8);
        wrk(ICU_PORT_OFS, 32'hf0);
        wrk(ctl(3), ICU_MODE_OFF);
        $display("t_port done");
    endtask : t_port

    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_edges();
        t_prescale();
        t_irq();
        t_port();
        wrap_up();
    end

    // Watchdog, well beyond the thousand or so cycles the tests need
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end
endmodule : icu_top_test

`default_nettype wire

// [shared/icu_pkg.sv]
// Constants shared by the input capture unit and its channels.
package icu_pkg;

    // Number of identical capture channels
    localparam int ICU_CHANNELS = 4;

    // Capture mode codes held in each control register
    localparam logic [3:0] ICU_MODE_OFF = 4'h0;
    localparam logic [3:0] ICU_MODE_FALL = 4'h4;
    localparam logic [3:0] ICU_MODE_RISE = 4'h5;
    localparam logic [3:0] ICU_MODE_RISE4 = 4'h6;
    localparam logic [3:0] ICU_MODE_RISE16 = 4'h7;

    // Last prescaler count before a capture fires
    localparam logic [3:0] ICU_DIV4_LAST = 4'h3;
    localparam logic [3:0] ICU_DIV16_LAST = 4'hf;

    // Register byte offsets
    localparam logic [7:0] ICU_CTRL_BASE = 8'h00;
    localparam logic [7:0] ICU_VALUE_BASE = 8'h10;
    localparam logic [7:0] ICU_FLAG_OFS = 8'h20;
    localparam logic [7:0] ICU_MASK_OFS = 8'h24;
    localparam logic [7:0] ICU_PORT_OFS = 8'h28;

    // Field positions inside the port register
    localparam int ICU_OUT_LSB = 0;
    localparam int ICU_DIR_LSB = 4;

    // Reset values
    localparam logic [3:0] ICU_CTRL_RST = 4'h0;
    localparam logic [3:0] ICU_MASK_RST = 4'h0;
    localparam logic [3:0] ICU_OUT_RST = 4'h0;
    localparam logic [3:0] ICU_DIR_RST = 4'hf;

    // Bus responses
    localparam logic [1:0] ICU_RESP_OKAY = 2'h0;
    localparam logic [1:0] ICU_RESP_SLVERR = 2'h2;

endpackage : icu_pkg

// [verilog/icu_channel.sv]
// One capture channel: pin synchroniser, edge select, prescaler, latch.
`timescale 1ns/1ps
`default_nettype none

module icu_channel
    import icu_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    input wire logic [3:0] mode_i,
    input wire logic [7:0] timer_high_i,
    input wire logic [7:0] timer_low_i,
    output logic event_o,
    output logic [15:0] value_o
);

    // All channel state in one word
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [3:0] pscnt;
        logic [15:0] value;
        logic evt;
    } icu_chan_state_type;

    icu_chan_state_type q; // Registered state
    icu_chan_state_type d; // Next state
    logic rise; // Synchronised rising edge
    logic fall; // Synchronised falling edge
    logic hit; // Capture fires this cycle

    // Next-state logic
    always_comb begin
        d = q;
        d.evt = 1'b0;
        hit = 1'b0;
        // pin level sampled
        // Pin level is watched whatever drives it, so port writes count
        d.sync1 = pin_i;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        rise = q.sync2 & ~q.prev;
        fall = ~q.sync2 & q.prev;
        unique case (mode_i)
            ICU_MODE_FALL: begin
                hit = fall;
            end
            ICU_MODE_RISE: begin
                hit = rise;
            end
            ICU_MODE_RISE4: begin
                if (rise) begin
                    if (q.pscnt == ICU_DIV4_LAST) begin
                        hit = 1'b1;
                        d.pscnt = '0;
                    end else begin
                        d.pscnt = 4'(q.pscnt + 4'h1);
                    end
                end
            end
            ICU_MODE_RISE16: begin
                if (rise) begin
                    if (q.pscnt == ICU_DIV16_LAST) begin
                        hit = 1'b1;
                        d.pscnt = '0;
                    end else begin
                        d.pscnt = 4'(q.pscnt + 4'h1);
                    end
                end
            end
            default: begin
                d.pscnt = '0;
            end
        endcase
        if (hit) begin
            d.value = {timer_high_i, timer_low_i};
        end
        d.evt = hit;
    end

    // State register; reset clears prescaler
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign event_o = q.evt;
    assign value_o = q.value;

    property p_edge_rise;
        @(posedge sys_clk_i) disable iff (reset_i)
        ($rose(pin_i) && mode_i == ICU_MODE_RISE)
            ##2 (mode_i == ICU_MODE_RISE) |=> event_o;
    endproperty
    a_edge_rise: assert property (p_edge_rise)
        else $error("rising edge not captured after sync delay");

    property p_value;
        @(posedge sys_clk_i) disable iff (reset_i)
        event_o |-> value_o == $past({timer_high_i, timer_low_i});
    endproperty
    a_value: assert property (p_value)
        else $error("captured value differs from timer");

    property p_off_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mode_i != ICU_MODE_RISE4 && mode_i != ICU_MODE_RISE16 &&
         mode_i != ICU_MODE_FALL && mode_i != ICU_MODE_RISE)
            |=> q.pscnt == 4'h0;
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("prescaler not cleared outside capture");

    property p_off_quiet;
        @(posedge sys_clk_i) disable iff (reset_i)
        (mode_i == ICU_MODE_OFF) |=> !event_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("capture while switched off");

    property p_div4;
        @(posedge sys_clk_i) disable iff (reset_i)
        ($past(mode_i) == ICU_MODE_RISE4 && event_o)
            |-> $past(q.pscnt) == ICU_DIV4_LAST;
    endproperty
    a_div4: assert property (p_div4)
        else $error("divide-by-four capture at wrong count");

    property p_reset_clear;
        @(posedge sys_clk_i)
        reset_i |=> q.pscnt == 4'h0 && !event_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset left prescaler running");

endmodule : icu_channel

`default_nettype wire

// [verilog/icu_top.sv]
// Input capture unit: four channels behind an AXI4-Lite register slave.
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module icu_top
    import icu_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [3:0] capture_input_pin_i,
    output logic [3:0] capture_input_pin_o,
    output logic [3:0] capture_input_pin_oe_o,
    input wire logic [7:0] timer_one_count_high_i,
    input wire logic [7:0] timer_one_count_low_i,
    output logic irq_o
);

    // All register and bus state in one word
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0][3:0] ctrl;
        logic [3:0] flags;
        logic [3:0] mask;
        logic [3:0] pout;
        logic [3:0] pdir;
    } icu_top_state_type;

    icu_top_state_type q; // Registered state
    icu_top_state_type d; // Next state
    logic [3:0] chan_evt; // Capture pulses from channels
    logic [3:0][15:0] chan_value; // Captured counts
    logic [3:0] flag_clr; // Write-one-to-clear request
    logic do_write; // Address and data both held
    logic [7:0] wa; // Word-aligned write address
    logic [7:0] ra; // Word-aligned read address

    for (genvar i = 0; i < ICU_CHANNELS; i++) begin : g_chan
        icu_channel u_chan (
            .sys_clk_i(sys_clk_i),
            .reset_i(reset_i),
            .pin_i(capture_input_pin_i[i]),
            .mode_i(q.ctrl[i]),
            .timer_high_i(timer_one_count_high_i),
            .timer_low_i(timer_one_count_low_i),
            .event_o(chan_evt[i]),
            .value_o(chan_value[i])
        );
    end

    // Handshake readies; a held beat blocks the next until answered
    assign s_axi_awready_o = ~q.aw_full & ~q.bvalid;
    assign s_axi_wready_o = ~q.w_full & ~q.bvalid;
    assign s_axi_arready_o = ~q.rvalid;
    assign do_write = q.aw_full & q.w_full & ~q.bvalid;
    assign wa = {q.aw_addr[7:2], 2'b00};
    assign ra = {s_axi_araddr_i[7:2], 2'b00};

    // Next-state logic: bus channels, register writes, flags, reads
    always_comb begin
        d = q;
        flag_clr = 4'h0;
        // Catch address and data in either order
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            d.aw_full = 1'b1;
            d.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            d.w_full = 1'b1;
            d.w_data = s_axi_wdata_i;
            d.w_strb = s_axi_wstrb_i;
        end
        // Response leaves once the master takes it
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
        end
        // Perform the write; only byte lane 0 holds fields
        if (do_write) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = ICU_RESP_OKAY;
            if (wa[7:4] == ICU_CTRL_BASE[7:4]) begin
                if (q.w_strb[0]) begin
                    d.ctrl[wa[3:2]] = q.w_data[3:0];
                end
            end else if (wa[7:4] == ICU_VALUE_BASE[7:4]) begin
                // Captured values are read-only; write ignored
                d.bresp = ICU_RESP_OKAY;
            end else if (wa == ICU_FLAG_OFS) begin
                if (q.w_strb[0]) begin
                    flag_clr = q.w_data[3:0];
                end
            end else if (wa == ICU_MASK_OFS) begin
                if (q.w_strb[0]) begin
                    d.mask = q.w_data[3:0];
                end
            end else if (wa == ICU_PORT_OFS) begin
                if (q.w_strb[0]) begin
                    d.pout = q.w_data[ICU_OUT_LSB +: 4];
                    d.pdir = q.w_data[ICU_DIR_LSB +: 4];
                end
            end else begin
                // Unmapped address
                d.bresp = ICU_RESP_SLVERR;
            end
        end
        // only software writes or reset clear; a new event beats the clear
        d.flags = (q.flags & ~flag_clr) | chan_evt;
        // Read answer once the master takes it
        if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            d.rvalid = 1'b1;
            d.rresp = ICU_RESP_OKAY;
            d.rdata = 32'h0;
            if (ra[7:4] == ICU_CTRL_BASE[7:4]) begin
                d.rdata[3:0] = q.ctrl[ra[3:2]];
            end else if (ra[7:4] == ICU_VALUE_BASE[7:4]) begin
                // Reading does not disturb later overwrites
                d.rdata[15:0] = chan_value[ra[3:2]];
            end else if (ra == ICU_FLAG_OFS) begin
                d.rdata[3:0] = q.flags;
            end else if (ra == ICU_MASK_OFS) begin
                d.rdata[3:0] = q.mask;
            end else if (ra == ICU_PORT_OFS) begin
                d.rdata[ICU_OUT_LSB +: 4] = q.pout;
                d.rdata[ICU_DIR_LSB +: 4] = q.pdir;
            end else begin
                // Unmapped reads answer zero with an error
                d.rresp = ICU_RESP_SLVERR;
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.ctrl <= {ICU_CTRL_RST, ICU_CTRL_RST, ICU_CTRL_RST,
                       ICU_CTRL_RST};
            q.mask <= ICU_MASK_RST;
            q.pout <= ICU_OUT_RST;
            q.pdir <= ICU_DIR_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    // Direction bit high means input, so the driver is off by default
    assign capture_input_pin_o = q.pout;
    assign capture_input_pin_oe_o = ~q.pdir;
    // Level interrupt while any unmasked flag is set
    assign irq_o = |(q.flags & q.mask);

    property p_flag_set;
        @(posedge sys_clk_i) disable iff (reset_i)
        (chan_evt != 4'h0) |=> (q.flags & $past(chan_evt)) ==
            $past(chan_evt);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("capture did not set its flag");

    property p_flag_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        (flag_clr == 4'h0) |=> (q.flags & $past(q.flags)) ==
            $past(q.flags);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped without a clear");

    property p_b_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        (s_axi_bvalid_o && !s_axi_bready_i)
            |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response withdrawn early");

    property p_wr_answer;
        @(posedge sys_clk_i) disable iff (reset_i)
        (q.aw_full && q.w_full) |=> s_axi_bvalid_o ##0
            (!q.aw_full && !q.w_full);
    endproperty
    a_wr_answer: assert property (p_wr_answer)
        else $error("write not answered next cycle");

endmodule : icu_top

`default_nettype wire
